// File: inc/tsg_pkg.sv
// Package for the TFT sync timing generator: register map, fields, reset values
// Operation
// [RULE_01] Back porch is (coarse+1)*8 plus fine trim
// [RULE_02] Fine trim is 4-bit, resets to 06h
// [RULE_03] Line width supported up to 2048 pixels
// [RULE_04] Hsync starts (front+1)*8 after active area
// [RULE_05] Hsync pulse lasts (width+1)*8 pixels
// [RULE_06] Height value: low byte plus bits 2..0
// [RULE_07] Active lines equal height value plus one
// [RULE_08] Blank value: low byte plus bits 1..0
// [RULE_09] Blank period lasts blank value plus one
// [RULE_10] Vsync starts sync-start field plus one lines
// [RULE_11] Fine trim added to coarse back porch
// [RULE_12] Active width is (coarse+1)*8 plus fine
// [RULE_13] Vsync lasts width field plus one lines
// [RULE_14] Pixel data idle during non-display periods
// [RULE_15] Host keeps front+sync+back above 64 pixels
// [RULE_16] Order: active, front porch, sync, back porch
// [RULE_17] Reserved horizontal bits read zero, ignore writes
package tsg_pkg;
  localparam int unsigned ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_DISP_COARSE = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_DISP_FINE   = 8'h15;
  localparam logic [ADDR_W-1:0] OFS_BP_COARSE   = 8'h16;
  localparam logic [ADDR_W-1:0] OFS_BP_FINE     = 8'h17;
  localparam logic [ADDR_W-1:0] OFS_FP_COARSE   = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_HS_WIDTH    = 8'h19;
  localparam logic [ADDR_W-1:0] OFS_VH_LOW      = 8'h1A;
  localparam logic [ADDR_W-1:0] OFS_VH_HIGH     = 8'h1B;
  localparam logic [ADDR_W-1:0] OFS_VB_LOW      = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_VB_HIGH     = 8'h1D;
  localparam logic [ADDR_W-1:0] OFS_VS_START    = 8'h1E;
  localparam logic [ADDR_W-1:0] OFS_VS_WIDTH    = 8'h1F;
  localparam logic [ADDR_W-1:0] OFS_CTRL        = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_STATUS      = 8'h24;
  localparam logic [7:0] RST_DISP_COARSE = 8'h4F;
  localparam logic [7:0] RST_DISP_FINE   = 8'h00;
  localparam logic [7:0] RST_BP_COARSE   = 8'h03;
  localparam logic [7:0] RST_BP_FINE     = 8'h06;
  localparam logic [7:0] RST_FP_COARSE   = 8'h1F;
  localparam logic [7:0] RST_HS_WIDTH    = 8'h00;
  localparam logic [7:0] RST_VH_LOW      = 8'hDF;
  localparam logic [7:0] RST_VH_HIGH     = 8'h00;
  localparam logic [7:0] RST_VB_LOW      = 8'h15;
  localparam logic [7:0] RST_VB_HIGH     = 8'h00;
  localparam logic [7:0] RST_VS_START    = 8'h0B;
  localparam logic [7:0] RST_VS_WIDTH    = 8'h00;
  localparam logic [7:0] RST_CTRL        = 8'h03;
  localparam logic [7:0] MSK_COARSE   = 8'h1F;
  localparam logic [7:0] MSK_FINE     = 8'h0F;
  localparam logic [7:0] MSK_VH_HIGH  = 8'h07;
  localparam logic [7:0] MSK_VB_HIGH  = 8'h03;
  localparam logic [7:0] MSK_VS_WIDTH = 8'h3F;
  localparam logic [7:0] MSK_CTRL     = 8'h0F;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_HIDLE    = 1;
  localparam int unsigned CTRL_VIDLE    = 2;
  localparam int unsigned CTRL_PIDLE    = 3;
  localparam int unsigned UNIT_SHIFT    = 3;
  localparam int unsigned HCNT_W        = 12;
  localparam int unsigned VCNT_W        = 12;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [3:0] {
    PH_ACTIVE = 4'b0001,
    PH_FRONT  = 4'b0010,
    PH_SYNC   = 4'b0100,
    PH_BACK   = 4'b1000
  } tsg_phase_t;
  typedef struct packed {
    logic hsync;
    logic vsync;
    logic de;
  } tsg_sync_t;
endpackage : tsg_pkg

// File: src/tsg_timing_gen.sv
// TFT sync timing generator with AXI4-Lite register slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module tsg_timing_gen
  import tsg_pkg::*;
#(
  parameter int unsigned DATA_W = 24,
  parameter int unsigned MAX_LINE = 2048
) (
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_b,
  // AXI4-Lite write
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // AXI4-Lite read
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // Panel side
  input  wire logic [DATA_W-1:0] pixel_in,
  output logic [DATA_W-1:0]      pixel_data_bus,
  output tsg_sync_t              sync_out
);

  // Phase counters are HCNT_W bits, so longer lines cannot be served
  if (DATA_W < 1 || MAX_LINE > (1 << (HCNT_W - 1))) begin : g_bad_param // RULE_03
    $error("tsg_timing_gen: unsupported parameters");
  end

  // Register file
  logic [7:0] display_width_coarse_ff, display_width_fine_ff;
  logic [7:0] back_porch_coarse_ff, back_porch_fine_ff;
  logic [7:0] front_porch_coarse_ff, hsync_width_field_ff;
  logic [7:0] vh_low_ff, vh_high_ff, vb_low_ff, vb_high_ff;
  logic [7:0] vsync_start_field_ff, vsync_width_field_ff, ctrl_ff;

  // Offsets are word indices; the byte address is four times the index
  function automatic logic [ADDR_W-1:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = {2'b00, a[ADDR_W-1:2]};
  endfunction : reg_index

  // Address decode used by both channels
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
    addr_hit = (a[1:0] == 2'b00) &&
               ((reg_index(a) >= OFS_DISP_COARSE && reg_index(a) <= OFS_CTRL) ||
                reg_index(a) == OFS_STATUS);
  endfunction : addr_hit

  // Write channel: address and data taken in either order
  logic              aw_held_ff, w_held_ff;
  logic [ADDR_W-1:0] awaddr_ff;
  logic [7:0]        wbyte_ff;
  logic              wstrb0_ff;
  wire               do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held_ff <= 1'b0;
      awaddr_ff  <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_ff <= 1'b1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      w_held_ff <= 1'b0;
      wbyte_ff  <= '0;
      wstrb0_ff <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_ff <= 1'b1;
      wbyte_ff  <= s_axi_wdata[7:0];
      wstrb0_ff <= s_axi_wstrb[0];
    end else if (do_write) begin
      w_held_ff <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_held_ff && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !w_held_ff && !(s_axi_wvalid && s_axi_wready);
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= addr_hit(awaddr_ff) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Reserved bits masked on write so they read back as zero
  wire wr_en = do_write && wstrb0_ff && addr_hit(awaddr_ff);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      display_width_coarse_ff <= RST_DISP_COARSE;
      display_width_fine_ff   <= RST_DISP_FINE;
      back_porch_coarse_ff    <= RST_BP_COARSE;   // RULE_01
      back_porch_fine_ff      <= RST_BP_FINE;     // RULE_02
      front_porch_coarse_ff   <= RST_FP_COARSE;   // RULE_04
      hsync_width_field_ff    <= RST_HS_WIDTH;    // RULE_05
      vh_low_ff               <= RST_VH_LOW;      // RULE_07
      vh_high_ff              <= RST_VH_HIGH;
      vb_low_ff               <= RST_VB_LOW;      // RULE_09
      vb_high_ff              <= RST_VB_HIGH;
      vsync_start_field_ff    <= RST_VS_START;    // RULE_10
      vsync_width_field_ff    <= RST_VS_WIDTH;
      ctrl_ff                 <= RST_CTRL;
    end else if (wr_en) begin
      case (reg_index(awaddr_ff))
        OFS_DISP_COARSE: display_width_coarse_ff <= wbyte_ff;
        OFS_DISP_FINE:   display_width_fine_ff   <= wbyte_ff & MSK_FINE;    // RULE_17
        OFS_BP_COARSE:   back_porch_coarse_ff    <= wbyte_ff & MSK_COARSE;  // RULE_17
        OFS_BP_FINE:     back_porch_fine_ff      <= wbyte_ff & MSK_FINE;    // RULE_17
        OFS_FP_COARSE:   front_porch_coarse_ff   <= wbyte_ff & MSK_COARSE;  // RULE_17
        OFS_HS_WIDTH:    hsync_width_field_ff    <= wbyte_ff & MSK_COARSE;  // RULE_17
        OFS_VH_LOW:      vh_low_ff               <= wbyte_ff;
        OFS_VH_HIGH:     vh_high_ff              <= wbyte_ff & MSK_VH_HIGH; // RULE_06
        OFS_VB_LOW:      vb_low_ff               <= wbyte_ff;
        OFS_VB_HIGH:     vb_high_ff              <= wbyte_ff & MSK_VB_HIGH; // RULE_08
        OFS_VS_START:    vsync_start_field_ff    <= wbyte_ff;
        OFS_VS_WIDTH:    vsync_width_field_ff    <= wbyte_ff & MSK_VS_WIDTH;
        OFS_CTRL:        ctrl_ff                 <= wbyte_ff & MSK_CTRL;
        default: begin
        end
      endcase
    end
  end

  // Derived lengths, all but v_blank minus one so counters end at the value
  logic [HCNT_W-1:0] h_act_m1, h_fp_m1, h_sw_m1, h_bp_m1;
  logic [VCNT_W-1:0] v_act_m1, v_fp_m1, v_sw_m1, v_bp_m1;
  logic [VCNT_W-1:0] v_blank;
  always_comb begin
    h_act_m1 = HCNT_W'(((display_width_coarse_ff + 9'd1) << UNIT_SHIFT)
               + display_width_fine_ff - 1);                               // RULE_12
    h_fp_m1  = HCNT_W'(((front_porch_coarse_ff + 9'd1) << UNIT_SHIFT) - 1); // RULE_04
    h_sw_m1  = HCNT_W'(((hsync_width_field_ff + 9'd1) << UNIT_SHIFT) - 1);  // RULE_05
    h_bp_m1  = HCNT_W'(((back_porch_coarse_ff + 9'd1) << UNIT_SHIFT)
               + back_porch_fine_ff - 1);                                  // RULE_01 RULE_11
    v_act_m1 = VCNT_W'({vh_high_ff[2:0], vh_low_ff});                      // RULE_06 RULE_07
    v_blank  = VCNT_W'({vb_high_ff[1:0], vb_low_ff}) + VCNT_W'(1);         // RULE_08 RULE_09
    v_fp_m1  = VCNT_W'(vsync_start_field_ff);                              // RULE_10
    v_sw_m1  = VCNT_W'(vsync_width_field_ff);                              // RULE_13
    // Vertical back porch fills whatever of the blank period is left
    if (v_blank > v_fp_m1 + v_sw_m1 + VCNT_W'(2)) begin
      v_bp_m1 = v_blank - v_fp_m1 - v_sw_m1 - VCNT_W'(3);
    end else begin
      v_bp_m1 = '0;
    end
  end

  // Horizontal phase machine
  tsg_phase_t        h_ph_ff, v_ph_ff;
  logic [HCNT_W-1:0] h_cnt_ff;
  logic [VCNT_W-1:0] v_cnt_ff;
  logic              h_end;
  wire               run = ctrl_ff[CTRL_EN_BIT];
  always_comb begin
    case (h_ph_ff)
      PH_ACTIVE: h_end = (h_cnt_ff >= h_act_m1);
      PH_FRONT:  h_end = (h_cnt_ff >= h_fp_m1);
      PH_SYNC:   h_end = (h_cnt_ff >= h_sw_m1);
      PH_BACK:   h_end = (h_cnt_ff >= h_bp_m1);
      default:   h_end = 1'b1;
    endcase
  end
  wire line_done = run && h_end && (h_ph_ff == PH_BACK);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      h_ph_ff  <= PH_ACTIVE;
      h_cnt_ff <= '0;
    end else if (!run) begin
      h_ph_ff  <= PH_ACTIVE;
      h_cnt_ff <= '0;
    end else if (h_end) begin
      h_cnt_ff <= '0;
      case (h_ph_ff)                                                       // RULE_16
        PH_ACTIVE: h_ph_ff <= PH_FRONT;
        PH_FRONT:  h_ph_ff <= PH_SYNC;
        PH_SYNC:   h_ph_ff <= PH_BACK;
        default:   h_ph_ff <= PH_ACTIVE;
      endcase
    end else begin
      h_cnt_ff <= h_cnt_ff + HCNT_W'(1);
    end
  end

  // Vertical phase machine, advances once per line
  logic v_end;
  always_comb begin
    case (v_ph_ff)
      PH_ACTIVE: v_end = (v_cnt_ff >= v_act_m1);
      PH_FRONT:  v_end = (v_cnt_ff >= v_fp_m1);
      PH_SYNC:   v_end = (v_cnt_ff >= v_sw_m1);
      PH_BACK:   v_end = (v_cnt_ff >= v_bp_m1);
      default:   v_end = 1'b1;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      v_ph_ff  <= PH_ACTIVE;
      v_cnt_ff <= '0;
    end else if (!run) begin
      v_ph_ff  <= PH_ACTIVE;
      v_cnt_ff <= '0;
    end else if (line_done) begin
      if (v_end) begin
        v_cnt_ff <= '0;
        case (v_ph_ff)                                                     // RULE_16
          PH_ACTIVE: v_ph_ff <= PH_FRONT;
          PH_FRONT:  v_ph_ff <= PH_SYNC;
          PH_SYNC:   v_ph_ff <= PH_BACK;
          default:   v_ph_ff <= PH_ACTIVE;
        endcase
      end else begin
        v_cnt_ff <= v_cnt_ff + VCNT_W'(1);
      end
    end
  end

  // Registered panel outputs; idle levels apply while stopped
  wire active = run && (h_ph_ff == PH_ACTIVE) && (v_ph_ff == PH_ACTIVE);
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sync_out       <= '{hsync: 1'b1, vsync: 1'b1, de: 1'b0};
      pixel_data_bus <= '0;
    end else begin
      sync_out.hsync <= run ? !(h_ph_ff == PH_SYNC) : ctrl_ff[CTRL_HIDLE];  // RULE_05
      sync_out.vsync <= run ? !(v_ph_ff == PH_SYNC) : ctrl_ff[CTRL_VIDLE];  // RULE_13
      sync_out.de    <= active;
      pixel_data_bus <= active ? pixel_in : {DATA_W{ctrl_ff[CTRL_PIDLE]}};  // RULE_14
    end
  end

  // Read channel, one cycle after address acceptance
  logic [7:0] rd_byte;
  always_comb begin
    case (reg_index(s_axi_araddr))
      OFS_DISP_COARSE: rd_byte = display_width_coarse_ff;
      OFS_DISP_FINE:   rd_byte = display_width_fine_ff;
      OFS_BP_COARSE:   rd_byte = back_porch_coarse_ff;
      OFS_BP_FINE:     rd_byte = back_porch_fine_ff;
      OFS_FP_COARSE:   rd_byte = front_porch_coarse_ff;
      OFS_HS_WIDTH:    rd_byte = hsync_width_field_ff;
      OFS_VH_LOW:      rd_byte = vh_low_ff;
      OFS_VH_HIGH:     rd_byte = vh_high_ff;
      OFS_VB_LOW:      rd_byte = vb_low_ff;
      OFS_VB_HIGH:     rd_byte = vb_high_ff;
      OFS_VS_START:    rd_byte = vsync_start_field_ff;
      OFS_VS_WIDTH:    rd_byte = vsync_width_field_ff;
      OFS_CTRL:        rd_byte = ctrl_ff;
      OFS_STATUS:      rd_byte = {v_ph_ff, h_ph_ff};
      default:         rd_byte = 8'h00;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= {24'h000000, addr_hit(s_axi_araddr) ? rd_byte : 8'h00};
        s_axi_rresp  <= addr_hit(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks
  sequence seq_sync_enter;
    run && h_end && h_ph_ff == PH_FRONT;
  endsequence
  chk_hfp_len: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(h_ph_ff == PH_FRONT) |-> (h_ph_ff == PH_FRONT)[*8]) // RULE_04
    else $error("front porch shorter than eight pixels");
  chk_hsync_follows: assert property (@(posedge mclk) disable iff (!rst_b)
    seq_sync_enter |=> ##1 !sync_out.hsync) // RULE_05
    else $error("hsync did not start after front porch");
  chk_order_h: assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(h_ph_ff) && run && $past(run) |-> h_ph_ff == PH_FRONT ? $past(h_ph_ff) == PH_ACTIVE :
    h_ph_ff == PH_SYNC ? $past(h_ph_ff) == PH_FRONT : 1'b1) // RULE_16
    else $error("horizontal phase order broken");
  chk_idle_data: assert property (@(posedge mclk) disable iff (!rst_b)
    !active |=> pixel_data_bus == {DATA_W{$past(ctrl_ff[CTRL_PIDLE])}}) // RULE_14
    else $error("pixel data not idle outside display");
  chk_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    back_porch_coarse_ff[7:5] == 3'b000 && back_porch_fine_ff[7:4] == 4'h0) // RULE_17
    else $error("reserved bits set");
  chk_bp_len: assert property (@(posedge mclk) disable iff (!rst_b)
    $rose(h_ph_ff == PH_BACK) |-> (h_ph_ff == PH_BACK)[*8]) // RULE_01
    else $error("back porch shorter than eight pixels");
  chk_v_line_step: assert property (@(posedge mclk) disable iff (!rst_b)
    $changed(v_ph_ff) && run && $past(run) |-> $past(line_done)) // RULE_07
    else $error("vertical phase moved inside a line");
  chk_vfp_start: assert property (@(posedge mclk) disable iff (!rst_b)
    line_done && v_ph_ff == PH_FRONT && v_cnt_ff == VCNT_W'(vsync_start_field_ff)
    |=> v_ph_ff == PH_SYNC) // RULE_10
    else $error("vsync start line wrong");
endmodule : tsg_timing_gen

// File: verification/tsg_panel_model.sv
// Panel model: measures sync timing and pixel levels seen at the panel pins
`timescale 1ns/1ns
module tsg_panel_model
  import tsg_pkg::*;
(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Panel pins
  input  wire tsg_sync_t   sync_in,
  input  wire logic [23:0] pix_in,
  input  wire logic [23:0] pix_ref,
  // Measurements
  output logic [15:0]      m_de,
  output logic [15:0]      m_fp,
  output logic [15:0]      m_hs,
  output logic [15:0]      m_bp,
  output logic [15:0]      m_vst,
  output logic [15:0]      m_vsw,
  output logic [15:0]      pix_err,
  output logic [11:0]      m_act,
  output logic [11:0]      m_blank
);
  logic        de_q_ff, hs_q_ff, vs_q_ff;
  logic [1:0]  last_ev_ff;
  logic [15:0] since_ff, vcnt_ff, vlow_ff;
  logic [11:0] rises_ff, hfalls_ff;
  wire de_rise = sync_in.de & ~de_q_ff;
  wire de_fall = ~sync_in.de & de_q_ff;
  wire hs_fall = ~sync_in.hsync & hs_q_ff;
  wire hs_rise = sync_in.hsync & ~hs_q_ff;
  wire vs_fall = ~sync_in.vsync & vs_q_ff;
  wire vs_rise = sync_in.vsync & ~vs_q_ff;
  wire any_ev  = de_rise | de_fall | hs_fall | hs_rise;
  // Counters start unknown and settle at the first edge, so only latched values matter
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      de_q_ff <= 1'b0;
      hs_q_ff <= 1'b1;
      vs_q_ff <= 1'b1;
      last_ev_ff <= 2'h0;
      pix_err <= 16'h0000;
    end else begin
      de_q_ff <= sync_in.de;
      hs_q_ff <= sync_in.hsync;
      vs_q_ff <= sync_in.vsync;
      since_ff <= any_ev ? 16'h0001 : since_ff + 16'h0001;
      if (de_fall) m_de <= since_ff;
      if (hs_fall && last_ev_ff == 2'h0) m_fp <= since_ff;
      if (hs_rise) m_hs <= since_ff;
      if (de_rise && last_ev_ff == 2'h2) m_bp <= since_ff;
      if (de_fall) last_ev_ff <= 2'h0;
      else if (hs_fall) last_ev_ff <= 2'h1;
      else if (hs_rise) last_ev_ff <= 2'h2;
      else if (de_rise) last_ev_ff <= 2'h3;
      hfalls_ff <= de_fall ? 12'h000 : hfalls_ff + {11'h000, hs_fall};
      if (de_rise && hfalls_ff > 12'h001) m_blank <= hfalls_ff - 12'h001;
      rises_ff <= vs_fall ? 12'h000 : rises_ff + {11'h000, de_rise};
      if (vs_fall) m_act <= rises_ff;
      vcnt_ff <= de_fall ? 16'h0001 : vcnt_ff + 16'h0001;
      if (vs_fall) m_vst <= vcnt_ff;
      vlow_ff <= vs_fall ? 16'h0001 : vlow_ff + 16'h0001;
      if (vs_rise) m_vsw <= vlow_ff;
      // Idle level is low: the pixel idle control bit resets to zero
      if (sync_in.de ? (pix_in !== pix_ref) : (pix_in !== 24'h000000)) begin
        pix_err <= pix_err + 16'h0001;
      end
    end
  end
endmodule : tsg_panel_model

// File: verification/tb_top.sv
// Testbench for the TFT sync timing generator
`timescale 1ns/1ns
`define CHK(nm, ev, gv) begin n_tests++; if ((gv) !== (ev)) begin bad_count++; \
  $display("wrong value %s expected %h seen %h", nm, ev, gv); end end
module tb_top
  import tsg_pkg::*;
;
  localparam logic [23:0] PIX_PAT = 24'h5A3C96;
  logic        mclk = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [23:0] pixel_out;
  logic [23:0] pix_src = PIX_PAT, pix_dly = PIX_PAT;
  tsg_sync_t   sync_w;
  logic [15:0] m_de, m_fp, m_hs, m_bp, m_vst, m_vsw, pix_err;
  logic [11:0] m_act, m_blank;
  int          bad_count = 0, n_tests = 0, cyc = 0;

  tsg_timing_gen tsg_timing_gen_i (.mclk(mclk), .rst_b(rst_b),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .pixel_in(pix_src),
    .pixel_data_bus(pixel_out), .sync_out(sync_w));
  tsg_panel_model tsg_panel_model_i (.mclk(mclk), .rst_b(rst_b), .sync_in(sync_w),
    .pix_in(pixel_out), .pix_ref(pix_dly), .m_de(m_de), .m_fp(m_fp), .m_hs(m_hs),
    .m_bp(m_bp), .m_vst(m_vst), .m_vsw(m_vsw), .pix_err(pix_err), .m_act(m_act),
    .m_blank(m_blank));

  initial begin
    forever #5 mclk = ~mclk;
  end

  // Moving pixel source, so a lost or extra pipeline stage shows up
  always @(posedge mclk) begin
    pix_src <= pix_src + 24'h000001;
    pix_dly <= pix_src;
  end

  // Printed offsets are not word aligned, so each one is a word index
  function automatic logic [7:0] ba(input logic [7:0] idx);
    return {idx[5:0], 2'b00};
  endfunction : ba

  task automatic axi_wr(input logic [7:0] idx, input logic [7:0] val);
    @(posedge mclk);
    s_axi_awaddr  <= ba(idx);
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= {24'h000000, val};
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk);
    s_axi_araddr  <= ba(idx);
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge mclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  task automatic t_reset_values();
    logic [7:0]  idx [9];
    logic [7:0]  rv [9];
    logic [31:0] d;
    logic [1:0]  r;
    idx = '{OFS_BP_COARSE, OFS_BP_FINE, OFS_FP_COARSE, OFS_HS_WIDTH, OFS_VH_LOW,
            OFS_VB_LOW, OFS_VS_START, OFS_DISP_COARSE, OFS_VS_WIDTH};
    rv  = '{8'h03, 8'h06, 8'h1F, 8'h00, 8'hDF, 8'h15, 8'h0B, 8'h4F, 8'h00};
    for (int i = 0; i < 9; i++) begin
      axi_rd(idx[i], d, r);
      `CHK("reset value", {24'h000000, rv[i]}, d)
    end
  endtask : t_reset_values

  task automatic t_reserved_bits();
    logic [7:0]  idx [4];
    logic [7:0]  mk [4];
    logic [31:0] d;
    logic [1:0]  r;
    idx = '{OFS_BP_COARSE, OFS_BP_FINE, OFS_FP_COARSE, OFS_HS_WIDTH};
    mk  = '{8'h1F, 8'h0F, 8'h1F, 8'h1F};
    for (int i = 0; i < 4; i++) begin
      axi_wr(idx[i], 8'hFF);
      axi_rd(idx[i], d, r);
      `CHK("masked readback", {24'h000000, mk[i]}, d)
    end
    // An address outside the map must answer with an error and no data
    axi_rd(8'h30, d, r);
    `CHK("unmapped resp", RESP_SLVERR, r)
    `CHK("unmapped data", 32'h00000000, d)
  endtask : t_reserved_bits

  task automatic t_timing(input int dc, df, fp, hw, bp, bf, vh, vb, vs);
    int ln, act;
    act = (dc + 1) * 8 + df;
    ln = act + (fp + 1) * 8 + (hw + 1) * 8 + (bp + 1) * 8 + bf;
    // Porch and sync sum stays above 64 pixels to keep the scan fifo fed
    axi_wr(OFS_DISP_COARSE, 8'(dc));
    axi_wr(OFS_DISP_FINE, 8'(df));
    axi_wr(OFS_FP_COARSE, 8'(fp));
    axi_wr(OFS_HS_WIDTH, 8'(hw));
    axi_wr(OFS_BP_COARSE, 8'(bp));
    axi_wr(OFS_BP_FINE, 8'(bf));
    axi_wr(OFS_VH_LOW, 8'(vh));
    axi_wr(OFS_VH_HIGH, 8'hF8);
    axi_wr(OFS_VB_LOW, 8'(vb));
    axi_wr(OFS_VB_HIGH, 8'hFC);
    axi_wr(OFS_VS_START, 8'(vs));
    axi_wr(OFS_VS_WIDTH, 8'h00);
    repeat (3) @(negedge sync_w.vsync);
    repeat (4) @(posedge mclk);
    `CHK("active width", 16'((dc + 1) * 8 + df), m_de)
    `CHK("front porch", 16'((fp + 1) * 8), m_fp)
    `CHK("hsync width", 16'((hw + 1) * 8), m_hs)
    `CHK("back porch", 16'((bp + 1) * 8 + bf), m_bp)
    `CHK("active lines", 12'(vh + 1), m_act)
    `CHK("blank lines", 12'(vb + 1), m_blank)
    // Measured from the last active pixel: rest of that line, then the start lines
    `CHK("vsync start line", 16'((vs + 1) * ln + ln - act), m_vst)
    `CHK("vsync width", 16'(ln), m_vsw)
    `CHK("pixel idle errors", 16'h0000, pix_err)
  endtask : t_timing

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : tally_and_finish

  // A hang ends the run; short frames keep the whole run well below this
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (2) @(posedge mclk);
    t_reset_values();
    t_reserved_bits();
    t_timing(0, 2, 0, 2, 3, 5, 3, 5, 1);
    t_timing(1, 0, 1, 0, 4, 15, 1, 3, 0);
    tally_and_finish();
  end
endmodule : tb_top
